// [pkg/rtcaf_pkg.sv]
/*
 * Constants, register map and types for the alarm flag and countdown timer block.
 * Assumes a 100 MHz system clock and register accesses synchronous to it.
 */
package rtcaf_pkg;

	// Clock rate and the fast countdown source derived from it.
	localparam int CLK_HZ        = 100_000_000;
	localparam int FAST_SRC_HZ   = 4096;
	localparam int FAST_TICK_CYC = CLK_HZ / FAST_SRC_HZ;
	localparam int FAST_DIV_W    = 16;
	localparam int SLOW_DIV_W    = 6;
	localparam logic [SLOW_DIV_W-1:0] SLOW_DIV_LAST = 6'h3f; // 4096 Hz ticks per 64 Hz tick.

	// Register offsets.
	localparam logic [7:0] ADDR_CTL     = 8'h01;
	localparam logic [7:0] ADDR_ALM_MIN = 8'h09;
	localparam logic [7:0] ADDR_ALM_HR  = 8'h0a;
	localparam logic [7:0] ADDR_ALM_DAY = 8'h0b;
	localparam logic [7:0] ADDR_ALM_WD  = 8'h0c;
	localparam logic [7:0] ADDR_TCO     = 8'h0e;
	localparam logic [7:0] ADDR_CNT     = 8'h0f;

	// Status and control register fields.
	localparam int CTL_LONG_EN   = 7;
	localparam int CTL_SHORT_EN  = 6;
	localparam int CTL_MSF       = 5;
	localparam int CTL_PULSE_SEL = 4;
	localparam int CTL_AF        = 3;
	localparam int CTL_TF        = 2;
	localparam int CTL_ALM_IE    = 1;
	localparam int CTL_CNT_IE    = 0;
	localparam logic [7:0] CTL_KEEP_MASK = 8'hd3;

	// Timer and clock out register fields.
	localparam int TCO_RUN     = 3;
	localparam int TCO_SRC_MSB = 1;
	localparam int TCO_SRC_LSB = 0;
	localparam logic [7:0] TCO_MASK = 8'h7b;

	// Alarm register layout: bit 7 disables the field.
	localparam int ALM_DIS = 7;
	localparam logic [7:0] ALM_MIN_MASK = 8'hff;
	localparam logic [7:0] ALM_HR_MASK  = 8'hbf;
	localparam logic [7:0] ALM_DAY_MASK = 8'hbf;
	localparam logic [7:0] ALM_WD_MASK  = 8'h87;

	// Reset values.
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] TCO_RST = 8'h00;
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [7:0] ALM_RST = 8'h80;
	localparam logic [7:0] CNT_ONE = 8'h01;

	// Countdown source selection.
	typedef enum logic [1:0] {SRC_4096HZ, SRC_64HZ, SRC_1HZ, SRC_1_60HZ} rtcaf_src_type;

endpackage

// [src/rtcaf_alarm_cmp.sv]
/*
 * Alarm comparator: compares the enabled alarm fields with the current time.
 * Assumes alarm registers and time values are stable flip-flop outputs.
 */
`timescale 1ns/100ps
`default_nettype none
module rtcaf_alarm_cmp
	import rtcaf_pkg::*;
(
	// Alarm registers.
	input  wire logic [7:0] alm_min,
	input  wire logic [7:0] alm_hr,
	input  wire logic [7:0] alm_day,
	input  wire logic [7:0] alm_wd,
	// Current time.
	input  wire logic [6:0] cur_min,
	input  wire logic [5:0] cur_hr,
	input  wire logic [5:0] cur_day,
	input  wire logic [2:0] cur_wd,
	// Result.
	output logic            match
);

	logic [3:0] dis;
	logic [3:0] eq;

	// Per-field equality and disable bits.
	assign dis = {alm_wd[ALM_DIS], alm_day[ALM_DIS], alm_hr[ALM_DIS], alm_min[ALM_DIS]};
	assign eq  = {alm_wd[2:0] == cur_wd, alm_day[5:0] == cur_day,
		alm_hr[5:0] == cur_hr, alm_min[6:0] == cur_min};

	// A match needs at least one enabled field and all enabled fields equal.
	assign match = (dis != 4'hf) && ((eq | dis) == 4'hf);

endmodule // rtcaf_alarm_cmp
`default_nettype wire

// [src/rtcaf_top.sv]
/*
 * Alarm flag, periodic tick flag and 8-bit reloading countdown timer with
 * interrupt output and a simple synchronous register port.
 * Assumes SEC_TICK and MIN_TICK are one-cycle pulses from the corrected
 * timekeeping chain and all inputs are synchronous to MCLK.
 */
`timescale 1ns/100ps
`default_nettype none
module rtcaf_top
	import rtcaf_pkg::*;
#(
	parameter int FAST_CYC = FAST_TICK_CYC
)(
	// Clock and reset.
	input  wire logic       MCLK,
	input  wire logic       RST,
	// Register port.
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	output logic      [7:0] REG_RDATA,
	// Timekeeping.
	input  wire logic       SEC_TICK,
	input  wire logic       MIN_TICK,
	input  wire logic [6:0] CUR_MIN,
	input  wire logic [5:0] CUR_HOUR,
	input  wire logic [5:0] CUR_DAY,
	input  wire logic [2:0] CUR_WDAY,
	// Interrupt.
	output logic            INT_N
);

	typedef struct packed {
		logic [7:0]            ctl;
		logic                  periodic_tick_flag;
		logic                  af;
		logic                  tf;
		logic [7:0]            tco;
		logic [7:0]            n;
		logic [7:0]            cnt;
		logic [3:0][7:0]       alm;
		logic                  match_prev;
		logic [FAST_DIV_W-1:0] div_fast;
		logic [SLOW_DIV_W-1:0] div_slow;
		logic                  per_pulse;
		logic                  tmr_pulse;
		logic                  wr_v;
		logic [7:0]            wr_a;
		logic [7:0]            wr_d;
		logic [7:0]            rdata;
	} rtcaf_state_type;

	rtcaf_state_type q;
	rtcaf_state_type d;

	logic          match;
	logic          tick_fast;
	logic          tick_slow;
	logic          src_tick;
	logic          per_evt;
	logic          run;
	logic          wr_ctl;
	logic          wr_cnt;
	logic          cnt_expire;
	logic          irq_per;
	logic          irq_tmr;
	logic          irq_alm;
	rtcaf_src_type src;

	// Alarm field comparison against the current time.
	rtcaf_alarm_cmp u_alarm_cmp (
		.alm_min (q.alm[0]),
		.alm_hr  (q.alm[1]),
		.alm_day (q.alm[2]),
		.alm_wd  (q.alm[3]),
		.cur_min (CUR_MIN),
		.cur_hr  (CUR_HOUR),
		.cur_day (CUR_DAY),
		.cur_wd  (CUR_WDAY),
		.match   (match)
	);

	// Source ticks: 4096 Hz and 64 Hz from the divider, slow ones from timekeeping.
	assign tick_fast = (q.div_fast == FAST_DIV_W'(FAST_CYC - 1));
	assign tick_slow = tick_fast && (q.div_slow == SLOW_DIV_LAST);
	assign src       = rtcaf_src_type'(q.tco[TCO_SRC_MSB:TCO_SRC_LSB]);
	always_comb begin
		case (src)
			SRC_4096HZ:  src_tick = tick_fast;
			SRC_64HZ:    src_tick = tick_slow;
			SRC_1HZ:     src_tick = SEC_TICK;
			SRC_1_60HZ:  src_tick = MIN_TICK;
			default:     src_tick = 1'b0;
		endcase
	end

	// Periodic event: seconds enable overrides minutes enable.
	assign per_evt = q.ctl[CTL_SHORT_EN] ? SEC_TICK
		: (q.ctl[CTL_LONG_EN] ? MIN_TICK : 1'b0);

	// Decoded, resynchronised writes and countdown state.
	assign wr_ctl     = q.wr_v && (q.wr_a == ADDR_CTL);
	assign wr_cnt     = q.wr_v && (q.wr_a == ADDR_CNT);
	assign run        = q.tco[TCO_RUN] && (q.n != CNT_RST);
	assign cnt_expire = run && src_tick && (q.cnt <= CNT_ONE);

	// Next-state logic for the whole block.
	always_comb begin
		d = q;

		// Capture the write one cycle before it is applied.
		d.wr_v = REG_WR;
		d.wr_a = REG_ADDR;
		d.wr_d = REG_WDATA;

		// Free-running prescaler.
		d.div_fast = tick_fast ? '0 : q.div_fast + 1'b1;
		if (tick_fast) begin
			d.div_slow = q.div_slow + 1'b1;
		end

		// Control and data registers.
		if (q.wr_v) begin
			case (q.wr_a)
				ADDR_CTL:     d.ctl    = q.wr_d & CTL_KEEP_MASK;
				ADDR_TCO:     d.tco    = q.wr_d & TCO_MASK;
				ADDR_ALM_MIN: d.alm[0] = q.wr_d & ALM_MIN_MASK;
				ADDR_ALM_HR:  d.alm[1] = q.wr_d & ALM_HR_MASK;
				ADDR_ALM_DAY: d.alm[2] = q.wr_d & ALM_DAY_MASK;
				ADDR_ALM_WD:  d.alm[3] = q.wr_d & ALM_WD_MASK;
				ADDR_CNT:     d.n      = q.wr_d;
				default:      d.n      = q.n;
			endcase
		end

		// Countdown: a new n lands in the counter at once, else count the source.
		if (wr_cnt) begin
			d.cnt = q.wr_d;
		end else if (run && src_tick) begin
			d.cnt = cnt_expire ? q.n : q.cnt - 1'b1;
		end

		// Alarm match edge detector.
		d.match_prev = match;

		// Flags: a write ANDs, an event in the same cycle still sets.
		d.af  = (wr_ctl ? q.af & q.wr_d[CTL_AF] : q.af)
			| (match && !q.match_prev);
		d.tf  = (wr_ctl ? q.tf & q.wr_d[CTL_TF] : q.tf) | cnt_expire;
		d.periodic_tick_flag = (wr_ctl ? q.periodic_tick_flag & q.wr_d[CTL_MSF] : q.periodic_tick_flag) | per_evt;

		// Periodic pulse lasts to the next 64 Hz tick; clearing the flag cuts it.
		if (per_evt) begin
			d.per_pulse = 1'b1;
		end else if (tick_slow || (wr_ctl && !q.wr_d[CTL_MSF])) begin
			d.per_pulse = 1'b0;
		end

		// Timer pulse lasts one source tick, at most 1/64 s; clearing TF cuts it.
		if (cnt_expire) begin
			d.tmr_pulse = 1'b1;
		end else if (tick_slow || (src_tick && !src[1]) || (wr_ctl && !q.wr_d[CTL_TF])) begin
			d.tmr_pulse = 1'b0;
		end

		// Register read data.
		if (REG_RD) begin
			case (REG_ADDR)
				ADDR_CTL:     d.rdata = q.ctl | {2'h0, q.periodic_tick_flag, 1'b0, q.af, q.tf, 2'h0};
				ADDR_TCO:     d.rdata = q.tco;
				ADDR_ALM_MIN: d.rdata = q.alm[0];
				ADDR_ALM_HR:  d.rdata = q.alm[1];
				ADDR_ALM_DAY: d.rdata = q.alm[2];
				ADDR_ALM_WD:  d.rdata = q.alm[3];
				ADDR_CNT:     d.rdata = q.cnt;
				default:      d.rdata = 8'h00;
			endcase
		end
	end

	// State register.
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			q            <= '0;
			q.ctl        <= CTL_RST;
			q.tco        <= TCO_RST;
			q.n          <= CNT_RST;
			q.cnt        <= CNT_RST;
			q.alm        <= {4{ALM_RST}};
			q.match_prev <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Interrupt sources, wired together onto one active-low output.
	assign irq_per = q.ctl[CTL_PULSE_SEL] ? q.per_pulse
		: (q.periodic_tick_flag && (q.ctl[CTL_SHORT_EN] || q.ctl[CTL_LONG_EN]));
	assign irq_tmr = q.ctl[CTL_CNT_IE]
		&& (q.ctl[CTL_PULSE_SEL] ? q.tmr_pulse : q.tf);
	assign irq_alm = q.ctl[CTL_ALM_IE] && q.af;
	assign INT_N     = !(irq_per || irq_tmr || irq_alm);
	assign REG_RDATA = q.rdata;

	// Single-cycle sequences used by the checks below.
	sequence seq_cnt_write;
		q.wr_v && (q.wr_a == ADDR_CNT);
	endsequence
	sequence seq_quiet_step;
		!q.wr_v && run && src_tick;
	endsequence

	// A new match sets the alarm flag on the next edge.
	AST_AF_SET: assert property (@(posedge MCLK) disable iff (RST)
		(match && !q.match_prev) |=> q.af)
		else $error("alarm flag not set on new match");

	// The alarm flag holds unless a status write clears it.
	AST_AF_HOLD: assert property (@(posedge MCLK) disable iff (RST)
		(q.af && !wr_ctl) |=> q.af)
		else $error("alarm flag dropped without a clear");

	// Writing zero to the alarm flag clears it when no match edge arrives.
	AST_AND_CLR: assert property (@(posedge MCLK) disable iff (RST)
		(wr_ctl && !q.wr_d[CTL_AF] && !(match && !q.match_prev)) |=> !q.af)
		else $error("alarm flag not cleared by zero write");

	// Counter decrements by one per source tick above one.
	AST_DEC: assert property (@(posedge MCLK) disable iff (RST)
		(seq_quiet_step and (q.cnt > CNT_ONE)) |=> (q.cnt == $past(q.cnt) - 8'h01))
		else $error("countdown did not decrement");

	// Zero stops the counter.
	AST_STOP: assert property (@(posedge MCLK) disable iff (RST)
		(!q.wr_v && (q.n == CNT_RST)) |=> $stable(q.cnt))
		else $error("counter moved while stopped");

	// Expiry reloads n and sets the timer flag together.
	AST_RELOAD: assert property (@(posedge MCLK) disable iff (RST)
		(seq_quiet_step and (q.cnt <= CNT_ONE)) |=> (q.tf && (q.cnt == $past(q.n))))
		else $error("no reload or flag at expiry");

	// A count write lands in both the reload value and the live counter.
	AST_NEW_N: assert property (@(posedge MCLK) disable iff (RST)
		seq_cnt_write |=> ((q.n == $past(q.wr_d)) && (q.cnt == $past(q.wr_d))))
		else $error("count write not applied at once");

	// In level mode with all sources disabled the interrupt stays inactive.
	AST_IRQ_GATE: assert property (@(posedge MCLK) disable iff (RST)
		(!q.ctl[CTL_CNT_IE] && !q.ctl[CTL_ALM_IE] && !q.ctl[CTL_SHORT_EN]
		&& !q.ctl[CTL_LONG_EN] && !q.ctl[CTL_PULSE_SEL]) |-> INT_N)
		else $error("interrupt active while all sources gated");

	// Every expiry sets the timer flag.
	AST_TF_SET: assert property (@(posedge MCLK) disable iff (RST)
		cnt_expire |=> q.tf)
		else $error("timer flag not set at expiry");

	// The timer flag holds unless a status write clears it.
	AST_TF_HOLD: assert property (@(posedge MCLK) disable iff (RST)
		(q.tf && !wr_ctl) |=> q.tf)
		else $error("timer flag dropped without a clear");

	// An enabled periodic event sets the tick flag.
	AST_MSF_SET: assert property (@(posedge MCLK) disable iff (RST)
		per_evt |=> q.periodic_tick_flag)
		else $error("tick flag not set on periodic event");

	// With both tick enables clear the tick flag never rises.
	AST_MSF_NONE: assert property (@(posedge MCLK) disable iff (RST)
		(!q.ctl[CTL_SHORT_EN] && !q.ctl[CTL_LONG_EN] && !q.periodic_tick_flag) |=> !q.periodic_tick_flag)
		else $error("tick flag set with ticks disabled");

	// A periodic event in pulse mode drives the interrupt on the next cycle.
	AST_PER_PULSE: assert property (@(posedge MCLK) disable iff (RST)
		(per_evt && q.ctl[CTL_PULSE_SEL] && !wr_ctl) |=> !INT_N)
		else $error("no periodic pulse on the interrupt");

	// An enabled alarm flag holds the interrupt active.
	AST_ALM_IRQ: assert property (@(posedge MCLK) disable iff (RST)
		(q.ctl[CTL_ALM_IE] && q.af) |-> !INT_N)
		else $error("alarm flag not shown on the interrupt");

	// In level mode an enabled timer flag holds the interrupt active.
	AST_TMR_LEVEL: assert property (@(posedge MCLK) disable iff (RST)
		(q.ctl[CTL_CNT_IE] && !q.ctl[CTL_PULSE_SEL] && q.tf) |-> !INT_N)
		else $error("timer flag not shown on the interrupt");

	// A count read returns the live counter.
	AST_RD_CNT: assert property (@(posedge MCLK) disable iff (RST)
		(REG_RD && (REG_ADDR == ADDR_CNT)) |=> (REG_RDATA == $past(q.cnt)))
		else $error("count read did not return the live counter");

	// A stopped timer keeps its count unless it is written.
	AST_RUN_OFF: assert property (@(posedge MCLK) disable iff (RST)
		(!q.tco[TCO_RUN] && !q.wr_v) |=> $stable(q.cnt))
		else $error("counter moved while disabled");

	// On the 64 Hz source the count moves only on the slow tick.
	AST_SRC_SLOW: assert property (@(posedge MCLK) disable iff (RST)
		(!q.wr_v && (src == SRC_64HZ) && !tick_slow) |=> $stable(q.cnt))
		else $error("counter moved between 64 Hz ticks");

	// A write is only captured on its first edge, never applied there.
	AST_WR_DELAY: assert property (@(posedge MCLK) disable iff (RST)
		(REG_WR && !q.wr_v) |=> ($stable(q.n) && $stable(q.ctl) && $stable(q.tco)))
		else $error("write applied before resynchronisation");

endmodule // rtcaf_top
`default_nettype wire

// [sim/rtcaf_host.sv]
/* Host model driving the register port of the alarm and timer block.
   Assumes the design takes each strobe on a rising clock edge. */
`timescale 1ns/100ps
`default_nettype none
module rtcaf_host (
	// Clock.
	input  wire logic       clk,
	// Register port.
	output logic            wr,
	output logic            rd,
	output logic      [7:0] addr,
	output logic      [7:0] wdata,
	input  wire logic [7:0] rdata
);
	// The bus starts idle.
	initial begin
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h5a;
		wdata = 8'ha5;
	end
	// One write; address and data are scrambled once released.
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(posedge clk) #1;
		wr = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask
	// One read; the data is taken after the edge that answers it.
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) #1;
		rd = 1'b1;
		addr = a;
		@(posedge clk) #1;
		rd = 1'b0;
		addr = ~a;
		d = rdata;
	endtask
	// Reads twice, and once more on a mismatch, as the count cannot be frozen.
	task automatic get2(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] x;
		get(a, x);
		get(a, d);
		if (x !== d)
			get(a, d);
	endtask
	// Clears the flags in m and writes the other bits back as they were.
	task automatic clr(input logic [7:0] m);
		logic [7:0] v;
		get(8'h01, v);
		put(8'h01, (v | 8'h2c) & ~m);
	endtask
	// Stops the countdown before loading n, then starts it on source s.
	task automatic set_timer(input logic [7:0] n, input logic [1:0] s);
		put(8'h0e, 8'h00);
		put(8'h0f, n);
		put(8'h0e, {6'h02, s});
	endtask
endmodule // rtcaf_host
`default_nettype wire

// [sim/rtcaf_top_bench.sv]
/* Self-checking bench for the alarm flag, tick flag and countdown timer.
   Assumes the host model rtcaf_host and a shortened fast tick. */
`timescale 1ns/100ps
`default_nettype none
module rtcaf_top_bench;
	typedef struct {int src; logic [7:0] n; int exp;} rtcaf_row_type;
	localparam int FC = 4;
	localparam logic [7:0] RA [4] = '{8'h01, 8'h0e, 8'h0f, 8'h09};
	logic       MCLK;
	logic       RST;
	logic       REG_WR;
	logic       REG_RD;
	logic [7:0] REG_ADDR;
	logic [7:0] REG_WDATA;
	logic [7:0] REG_RDATA;
	logic       SEC_TICK;
	logic       MIN_TICK;
	logic [6:0] CUR_MIN;
	logic [5:0] CUR_HOUR;
	logic [5:0] CUR_DAY;
	logic [2:0] CUR_WDAY;
	logic       INT_N;
	logic [7:0] v;
	int         p;
	int         fails;
	int         compares;
	rtcaf_row_type rows [4] = '{'{0, 8'd2, 8}, '{1, 8'd2, 512}, '{2, 8'd20, 320},
		'{3, 8'd20, 320}};

	// Design and host model.
	rtcaf_top #(.FAST_CYC(FC)) uut (.MCLK(MCLK), .RST(RST), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_RDATA(REG_RDATA), .SEC_TICK(SEC_TICK), .MIN_TICK(MIN_TICK),
		.CUR_MIN(CUR_MIN), .CUR_HOUR(CUR_HOUR), .CUR_DAY(CUR_DAY), .CUR_WDAY(CUR_WDAY),
		.INT_N(INT_N));
	rtcaf_host host (.clk(MCLK), .wr(REG_WR), .rd(REG_RD), .addr(REG_ADDR),
		.wdata(REG_WDATA), .rdata(REG_RDATA));

	// The clock toggles every half period.
	always #5 MCLK = ~MCLK;

	// Compares a register value.
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: value %h, wanted %h", $time, g, e);
		end
	endtask
	// Compares a cycle count.
	task automatic chkn(input int g, input int e);
		compares++;
		if (g != e) begin
			fails++;
			$display("unexpected at %0t: %0d cycles, wanted %0d", $time, g, e);
		end
	endtask
	// One-cycle time base pulses.
	task automatic tick(input logic s, input logic m);
		@(posedge MCLK) #1;
		SEC_TICK = s;
		MIN_TICK = m;
		@(posedge MCLK) #1;
		SEC_TICK = 1'b0;
		MIN_TICK = 1'b0;
	endtask
	// Reports whether the interrupt went low in c cycles after s skipped ones.
	task automatic lowin(input int s, input int c, output logic [7:0] lo);
		lo = 8'h00;
		repeat (s) @(posedge MCLK);
		repeat (c) begin
			@(posedge MCLK) #1;
			if (INT_N === 1'b0)
				lo = 8'h01;
		end
	endtask
	// Cycles between two falls of the interrupt; slow sources get a tick each 16.
	task automatic period(input int src, output int n);
		int  f;
		logic pr;
		f = 0;
		n = 0;
		pr = INT_N;
		for (int k = 0; k < 3000 && f < 2; k++) begin
			@(posedge MCLK) #1;
			SEC_TICK = (src >= 2) && (k % 16 == 0);
			MIN_TICK = (src >= 2) && (k % 16 == 0);
			if (f == 1)
				n++;
			if (INT_N === 1'b0 && pr === 1'b1)
				f++;
			pr = INT_N;
		end
		@(posedge MCLK) #1;
		SEC_TICK = 1'b0;
		MIN_TICK = 1'b0;
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Cuts a hang short.
	initial begin
		#300000;
		fails++;
		$display("unexpected at %0t: watchdog ran out", $time);
		wrap_up();
	end

	// Main sequence.
	initial begin
		MCLK = 1'b0;
		RST = 1'b1;
		SEC_TICK = 1'b0;
		MIN_TICK = 1'b0;
		CUR_MIN = 7'h00;
		CUR_HOUR = 6'h07;
		CUR_DAY = 6'h01;
		CUR_WDAY = 3'h2;
		fails = 0;
		compares = 0;
		repeat (5) @(posedge MCLK);
		#1 RST = 1'b0;
		for (int i = 0; i < 4; i++) begin
			host.get(RA[i], v);
			chk(v, (i == 3) ? 8'h80 : 8'h00);
		end
		host.put(8'h0e, 8'hff);
		host.get(8'h0e, v);
		chk(v, 8'h7b);
		host.put(8'h20, 8'hff);
		host.get(8'h20, v);
		chk(v, 8'h00);
		// Countdown period for each source, in pulse mode with the timer irq on.
		host.put(8'h01, 8'h11);
		foreach (rows[i]) begin
			host.set_timer(rows[i].n, rows[i].src[1:0]);
			period(rows[i].src, p);
			chkn(p, rows[i].exp);
		end
		host.set_timer(8'd200, 2'd1);
		repeat (600) @(posedge MCLK);
		host.get2(8'h0f, v);
		chk({7'h00, v < 8'd200 && v > 8'd196}, 8'h01);
		host.put(8'h0e, 8'h08);
		host.put(8'h0f, 8'h03);
		host.get(8'h0f, v);
		chk({7'h00, v <= 8'h03}, 8'h01);
		period(0, p);
		chkn(p, 12);
		host.put(8'h0f, 8'h00);
		lowin(8, 100, v);
		chk(v, 8'h00);
		host.get(8'h01, v);
		chk(v & 8'h04, 8'h04);
		host.put(8'h0e, 8'h00);
		host.put(8'h01, 8'h04);
		lowin(2, 5, v);
		chk(v, 8'h00);
		host.put(8'h01, 8'h05);
		lowin(2, 5, v);
		chk(v, 8'h01);
		host.clr(8'h04);
		lowin(2, 5, v);
		chk(v, 8'h00);
		// Alarm on the minute field only; the hour field is disabled and differs.
		host.put(8'h09, 8'h15);
		host.put(8'h01, 8'h02);
		CUR_MIN = 7'h15;
		lowin(0, 4, v);
		chk(v, 8'h01);
		host.clr(8'h08);
		lowin(2, 5, v);
		chk(v, 8'h00);
		CUR_MIN = 7'h16;
		repeat (3) @(posedge MCLK);
		#1 CUR_MIN = 7'h15;
		lowin(0, 4, v);
		chk(v, 8'h01);
		// All four fields enabled; the weekday is the last to agree.
		host.clr(8'h08);
		host.put(8'h0c, 8'h03);
		host.put(8'h0a, 8'h08);
		host.put(8'h0b, 8'h12);
		CUR_HOUR = 6'h08;
		CUR_DAY = 6'h12;
		lowin(0, 4, v);
		chk(v, 8'h00);
		CUR_WDAY = 3'h3;
		lowin(0, 4, v);
		chk(v, 8'h01);
		// Periodic ticks in pulse mode.
		host.put(8'h01, 8'h58);
		tick(1'b1, 1'b0);
		lowin(0, 3, v);
		chk(v, 8'h01);
		repeat (300) @(posedge MCLK);
		lowin(0, 3, v);
		chk(v, 8'h00);
		tick(1'b1, 1'b0);
		lowin(0, 3, v);
		chk(v, 8'h01);
		repeat (300) @(posedge MCLK);
		host.put(8'h01, 8'hb8);
		tick(1'b1, 1'b0);
		lowin(0, 20, v);
		chk(v, 8'h00);
		tick(1'b0, 1'b1);
		lowin(0, 3, v);
		chk(v, 8'h01);
		repeat (300) @(posedge MCLK);
		// All three flags set, then cleared one at a time.
		host.set_timer(8'h01, 2'd0);
		repeat (20) @(posedge MCLK);
		host.put(8'h0e, 8'h00);
		host.get(8'h01, v);
		chk(v, 8'hbc);
		host.clr(8'h04);
		host.get(8'h01, v);
		chk(v, 8'hb8);
		host.clr(8'h20);
		host.get(8'h01, v);
		chk(v, 8'h98);
		host.clr(8'h08);
		host.get(8'h01, v);
		chk(v, 8'h90);
		host.put(8'h01, 8'h10);
		tick(1'b1, 1'b1);
		lowin(0, 20, v);
		chk(v, 8'h00);
		host.get(8'h01, v);
		chk(v, 8'h10);
		// A second reset while the timer flag holds the interrupt active.
		host.set_timer(8'd5, 2'd0);
		host.put(8'h01, 8'h01);
		lowin(30, 2, v);
		chk(v, 8'h01);
		@(posedge MCLK) #1 RST = 1'b1;
		repeat (2) @(posedge MCLK);
		#1 RST = 1'b0;
		lowin(0, 5, v);
		chk(v, 8'h00);
		for (int i = 0; i < 4; i++) begin
			host.get(RA[i], v);
			chk(v, (i == 3) ? 8'h80 : 8'h00);
		end
		wrap_up();
	end
endmodule // rtcaf_top_bench
`default_nettype wire
